// >>> core/tpg_pkg.sv
// Constants, field positions and carrier types of the three-port GPIO block
package tpg_pkg;

   // ==========================================================
   // Sizes
   localparam int TPG_W     = 8;
   localparam int TPG_NPORT = 3;
   localparam int TPG_NPIN  = 26;

   // ==========================================================
   // APB address layout
   localparam int TPG_CFG_SPACE_BIT = 20;
   localparam int TPG_IOB_LSB       = 2;
   localparam int TPG_IOB_MSB       = 17;

   // ==========================================================
   // Port register offsets within a bank
   localparam logic [1:0] TPG_OFF_DATA  = 2'h0;
   localparam logic [1:0] TPG_OFF_DIR   = 2'h1;
   localparam logic [1:0] TPG_OFF_OTYPE = 2'h2;
   localparam logic [1:0] TPG_OFF_PU    = 2'h3;
   localparam logic [2:0] TPG_OFF_LOCK  = 3'h0;
   localparam logic [2:0] TPG_OFF_POL   = 3'h1;
   localparam logic [2:0] TPG_OFF_ROUTE = 3'h2;

   // ==========================================================
   // Configuration register indexes
   localparam logic [7:0] TPG_IDX_CHIP_CFG1 = 8'h21;
   localparam logic [7:0] TPG_IDX_CHIP_CFG2 = 8'h22;
   localparam logic [7:0] TPG_IDX_CHIP_CFG3 = 8'h26;
   localparam logic [7:0] TPG_IDX_ACTIVATE  = 8'h30;
   localparam logic [7:0] TPG_IDX_FUNC_EN2  = 8'h40;
   localparam logic [7:0] TPG_IDX_PWR_CTL3  = 8'h49;
   localparam logic [7:0] TPG_IDX_PWR_CTL5  = 8'h4B;
   localparam logic [7:0] TPG_IDX_BASE_HI   = 8'h60;
   localparam logic [7:0] TPG_IDX_BASE_LO   = 8'h61;

   // ==========================================================
   // Field positions
   localparam int TPG_BANK_SEL_BIT = 7;
   localparam int TPG_FE2_GPIO_BIT = 7;
   localparam int TPG_ACT_BIT      = 0;
   localparam int TPG_CFG1_EXT_BIT = 4;
   localparam int TPG_CFG1_P3_BIT  = 3;
   localparam int TPG_CFG3_PAR_BIT = 0;
   localparam int TPG_PWR3_G15_BIT = 1;
   localparam int TPG_PWR3_G16_BIT = 0;
   localparam int TPG_PWR3_IR_BIT  = 3;
   localparam int TPG_PWR3_P37_BIT = 4;
   localparam int TPG_PWR5_P33_BIT = 6;
   localparam logic [7:0] TPG_LOCK_MASK = 8'hF0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] TPG_RST_DATA  = 8'hFF;
   localparam logic [7:0] TPG_RST_DIR   = 8'h00;
   localparam logic [7:0] TPG_RST_OTYPE = 8'h00;
   localparam logic [7:0] TPG_RST_PU    = 8'hFF;
   localparam logic [7:0] TPG_RST_CFG   = 8'h00;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] otype;
      logic [7:0] pu;
   } tpg_port_t;

   localparam tpg_port_t TPG_RST_PORT =
      '{TPG_RST_DATA, TPG_RST_DIR, TPG_RST_OTYPE, TPG_RST_PU};

endpackage : tpg_pkg

// >>> core/tpg_top.sv
// Three-port GPIO block with APB register access
`timescale 1ns/1ps
`default_nettype none
module tpg_top
   import tpg_pkg::*;
(
   // Clock and reset
   input  wire logic                i_mclk,
   input  wire logic                i_sys_rst,
   // APB slave
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [31:0]         i_paddr,
   input  wire logic [31:0]         i_pwdata,
   output logic      [31:0]         o_prdata,
   output logic                     o_pready,
   output logic                     o_pslverr,
   // Pins
   input  wire logic [TPG_NPIN-1:0] i_gpio_in,
   output logic      [TPG_NPIN-1:0] o_gpio_out,
   output logic      [TPG_NPIN-1:0] o_gpio_oe,
   output logic      [TPG_NPIN-1:0] o_pullup_en,
   output logic      [TPG_NPIN-1:0] o_gpio_sel,
   // Power control paths
   output logic      [2:0]          o_wake_src,
   output logic                     o_power_on_control_out_src
);
   // ==========================================================
   // Pin input synchronisers
   logic [TPG_NPIN-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
   logic [TPG_NPIN-1:0] s1_next, s2_next, s3_next, flt_next;

   always_comb begin
      s1_next  = i_gpio_in;
      s2_next  = s1_reg;
      s3_next  = s2_reg;
      flt_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & flt_reg);
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         flt_reg <= '0;
      end else begin
         s1_reg  <= s1_next;
         s2_reg  <= s2_next;
         s3_reg  <= s3_next;
         flt_reg <= flt_next;
      end
   end
   // ==========================================================
   // Register state
   tpg_port_t  port_reg  [TPG_NPORT];
   tpg_port_t  port_next [TPG_NPORT];
   logic [7:0] lock_reg, lock_next;
   logic       pol_reg, pol_next;
   logic       route_reg, route_next;
   logic [7:0] cfg1_reg, cfg2_reg, cfg3_reg, act_reg, fe2_reg;
   logic [7:0] pwr3_reg, pwr5_reg, bhi_reg, blo_reg;
   logic [7:0] cfg1_next, cfg2_next, cfg3_next, act_next, fe2_next;
   logic [7:0] pwr3_next, pwr5_next, bhi_next, blo_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   // ==========================================================
   // Decode
   logic        cfg_sp, port_hit, bank, err, wr_en;
   logic        act12, act3, p_act;
   logic [7:0]  cidx, rd_byte, wb, lmask;
   logic [15:0] iob;
   logic [2:0]  off;
   int          pidx;
   logic [23:0] pin_rd;

   always_comb begin
      pin_rd     = flt_reg[23:0];
      pin_rd[12] = pwr3_reg[TPG_PWR3_IR_BIT] ? flt_reg[12] : flt_reg[24];
      pin_rd[13] = cfg3_reg[TPG_CFG3_PAR_BIT] ? flt_reg[13] : flt_reg[25];
      act12    = act_reg[TPG_ACT_BIT] & fe2_reg[TPG_FE2_GPIO_BIT];
      act3     = act_reg[TPG_ACT_BIT];
      cfg_sp   = i_paddr[TPG_CFG_SPACE_BIT];
      cidx     = i_paddr[9:2];
      iob      = i_paddr[TPG_IOB_MSB:TPG_IOB_LSB];
      off      = iob[2:0];
      bank     = cfg2_reg[TPG_BANK_SEL_BIT];
      port_hit = !cfg_sp && (i_paddr[31:21] == 11'h000) &&
                 (i_paddr[19:18] == 2'h0) &&
                 (iob[15:3] == {bhi_reg, blo_reg[7:3]});
      pidx     = !bank ? (off[2] ? 1 : 0) : 2;
      p_act    = (pidx == 2) ? act3 : act12;
      err      = 1'b0;
      rd_byte  = 8'h00;
      if (cfg_sp) begin
         case (cidx)
            TPG_IDX_CHIP_CFG1: rd_byte = cfg1_reg;
            TPG_IDX_CHIP_CFG2: rd_byte = cfg2_reg;
            TPG_IDX_CHIP_CFG3: rd_byte = cfg3_reg;
            TPG_IDX_ACTIVATE:  rd_byte = act_reg;
            TPG_IDX_FUNC_EN2:  rd_byte = fe2_reg;
            TPG_IDX_PWR_CTL3:  rd_byte = pwr3_reg;
            TPG_IDX_PWR_CTL5:  rd_byte = pwr5_reg;
            TPG_IDX_BASE_HI:   rd_byte = bhi_reg;
            TPG_IDX_BASE_LO:   rd_byte = blo_reg;
            default:           err     = 1'b1;
         endcase
      end else if (port_hit) begin
         if (!bank || off[2]) begin
            if (p_act) begin
               case (off[1:0])
                  TPG_OFF_DATA:  rd_byte = (port_reg[pidx].dir &
                                            port_reg[pidx].data) |
                                           (~port_reg[pidx].dir &
                                            pin_rd[pidx*8 +: 8]);
                  TPG_OFF_DIR:   rd_byte = port_reg[pidx].dir;
                  TPG_OFF_OTYPE: rd_byte = port_reg[pidx].otype;
                  default:       rd_byte = port_reg[pidx].pu;
               endcase
            end
         end else begin
            case (off)
               TPG_OFF_LOCK:  rd_byte = lock_reg & TPG_LOCK_MASK;
               TPG_OFF_POL:   rd_byte = {7'h00, pol_reg};
               TPG_OFF_ROUTE: rd_byte = {7'h00, route_reg};
               default:       err     = 1'b1;
            endcase
            if (!act12) begin
               rd_byte = 8'h00;
            end
         end
      end else begin
         err = 1'b1;
      end
      wr_en = i_psel & i_penable & i_pwrite & pready_reg & !err;
   end
   // ==========================================================
   // Bus answer and register next values
   always_comb begin
      pready_next  = i_psel & i_penable & !pready_reg;
      prdata_next  = pready_next ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr_next = pready_next & err;
      for (int p = 0; p < TPG_NPORT; p++) begin
         port_next[p] = port_reg[p];
      end
      lock_next  = lock_reg;
      pol_next   = pol_reg;
      route_next = route_reg;
      cfg1_next  = cfg1_reg;
      cfg2_next  = cfg2_reg;
      cfg3_next  = cfg3_reg;
      act_next   = act_reg;
      fe2_next   = fe2_reg;
      pwr3_next  = pwr3_reg;
      pwr5_next  = pwr5_reg;
      bhi_next   = bhi_reg;
      blo_next   = blo_reg;
      wb         = i_pwdata[7:0];
      lmask      = (pidx == 0) ? (lock_reg & TPG_LOCK_MASK) : 8'h00;
      if (wr_en && cfg_sp) begin
         case (cidx)
            TPG_IDX_CHIP_CFG1: cfg1_next = wb;
            TPG_IDX_CHIP_CFG2: cfg2_next = wb;
            TPG_IDX_CHIP_CFG3: cfg3_next = wb;
            TPG_IDX_ACTIVATE:  act_next  = wb;
            TPG_IDX_FUNC_EN2:  fe2_next  = wb;
            TPG_IDX_PWR_CTL3:  pwr3_next = wb;
            TPG_IDX_PWR_CTL5:  pwr5_next = wb;
            TPG_IDX_BASE_HI:   bhi_next  = wb;
            default:           blo_next  = wb;
         endcase
      end else if (wr_en && (!bank || off[2]) && p_act) begin
         case (off[1:0])
            TPG_OFF_DATA:  port_next[pidx].data =
                              (port_reg[pidx].data & lmask &
                               port_reg[pidx].dir) |
                              (wb & ~(lmask & port_reg[pidx].dir));
            TPG_OFF_DIR:   port_next[pidx].dir =
                              (port_reg[pidx].dir & lmask) | (wb & ~lmask);
            TPG_OFF_OTYPE: port_next[pidx].otype =
                              (port_reg[pidx].otype & lmask) | (wb & ~lmask);
            default:       port_next[pidx].pu =
                              (port_reg[pidx].pu & lmask) | (wb & ~lmask);
         endcase
      end else if (wr_en && act12) begin
         case (off)
            TPG_OFF_LOCK:  lock_next  = lock_reg | (wb & TPG_LOCK_MASK);
            TPG_OFF_POL:   pol_next   = wb[0];
            default:       route_next = wb[0];
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         for (int p = 0; p < TPG_NPORT; p++) begin
            port_reg[p] <= TPG_RST_PORT;
         end
         lock_reg    <= TPG_RST_CFG;
         pol_reg     <= 1'b0;
         route_reg   <= 1'b0;
         cfg1_reg    <= TPG_RST_CFG;
         cfg2_reg    <= TPG_RST_CFG;
         cfg3_reg    <= TPG_RST_CFG;
         act_reg     <= TPG_RST_CFG;
         fe2_reg     <= TPG_RST_CFG;
         pwr3_reg    <= TPG_RST_CFG;
         pwr5_reg    <= TPG_RST_CFG;
         bhi_reg     <= TPG_RST_CFG;
         blo_reg     <= TPG_RST_CFG;
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         for (int p = 0; p < TPG_NPORT; p++) begin
            port_reg[p] <= port_next[p];
         end
         lock_reg    <= lock_next;
         pol_reg     <= pol_next;
         route_reg   <= route_next;
         cfg1_reg    <= cfg1_next;
         cfg2_reg    <= cfg2_next;
         cfg3_reg    <= cfg3_next;
         act_reg     <= act_next;
         fe2_reg     <= fe2_next;
         pwr3_reg    <= pwr3_next;
         pwr5_reg    <= pwr5_next;
         bhi_reg     <= bhi_next;
         blo_reg     <= blo_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end
   // ==========================================================
   // Pin drive
   logic [TPG_NPIN-1:0] out_reg, oe_reg, pue_reg, sel_reg;
   logic [TPG_NPIN-1:0] out_next, oe_next, pue_next, sel_next;
   logic [2:0]          wake_reg, wake_next;
   logic                power_on_control_out_reg, power_on_control_out_next;
   logic [TPG_NPIN-1:0] d_v, dir_v, ot_v, pu_v, act_v;
   logic                route_on, g10_act;

   always_comb begin
      for (int i = 0; i < 24; i++) begin
         d_v[i]   = port_reg[i/8].data[i%8];
         dir_v[i] = port_reg[i/8].dir[i%8];
         ot_v[i]  = port_reg[i/8].otype[i%8];
         pu_v[i]  = port_reg[i/8].pu[i%8];
         act_v[i] = (i < 16) ? act12 : act3;
      end
      d_v[25:24]   = d_v[13:12];
      dir_v[25:24] = dir_v[13:12];
      ot_v[25:24]  = ot_v[13:12];
      pu_v[25:24]  = pu_v[13:12];
      act_v[25:24] = {act12, act12};
      route_on = route_reg & ~port_reg[0].data[1];
      g10_act  = pol_reg ? flt_reg[0] : ~flt_reg[0];
      if (route_on) begin
         d_v[1] = g10_act;
      end
      sel_next     = '1;
      sel_next[5]  = pwr3_reg[TPG_PWR3_G15_BIT];
      sel_next[6]  = pwr3_reg[TPG_PWR3_G16_BIT];
      sel_next[12] = pwr3_reg[TPG_PWR3_IR_BIT];
      sel_next[24] = cfg1_reg[TPG_CFG1_EXT_BIT];
      sel_next[13] = cfg3_reg[TPG_CFG3_PAR_BIT];
      sel_next[25] = cfg1_reg[TPG_CFG1_EXT_BIT];
      for (int i = 16; i < 24; i++) begin
         sel_next[i] = cfg1_reg[TPG_CFG1_P3_BIT];
      end
      sel_next[19] = pwr5_reg[TPG_PWR5_P33_BIT];
      sel_next[23] = pwr3_reg[TPG_PWR3_P37_BIT];
      out_next = ot_v & d_v;
      oe_next  = act_v & sel_next & dir_v & (ot_v | ~d_v);
      pue_next = act_v & sel_next & pu_v;
      wake_next = {flt_reg[3] & ~dir_v[3], flt_reg[2] & ~dir_v[2],
                   flt_reg[0] & ~dir_v[0]} & {3{act12}};
      power_on_control_out_next = flt_reg[0] & ~dir_v[0] & act12;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         out_reg   <= '0;
         oe_reg    <= '0;
         pue_reg   <= '0;
         sel_reg   <= '0;
         wake_reg  <= 3'h0;
         power_on_control_out_reg <= 1'b0;
      end else begin
         out_reg   <= out_next;
         oe_reg    <= oe_next;
         pue_reg   <= pue_next;
         sel_reg   <= sel_next;
         wake_reg  <= wake_next;
         power_on_control_out_reg <= power_on_control_out_next;
      end
   end
   assign o_prdata    = prdata_reg;
   assign o_pready    = pready_reg;
   assign o_pslverr   = pslverr_reg;
   assign o_gpio_out  = out_reg;
   assign o_gpio_oe   = oe_reg;
   assign o_pullup_en = pue_reg;
   assign o_gpio_sel  = sel_reg;
   assign o_wake_src  = wake_reg;
   assign o_power_on_control_out_src = power_on_control_out_reg;
   // ==========================================================
   // Checks
   a_pready_pulse: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
      else $error("pready not a single pulse");
   a_lock_sticky: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      ($past(lock_reg) & ~lock_reg) == 8'h00)
      else $error("lock bit cleared");
   a_lock_freeze: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      lock_reg[7] |=> port_reg[0].otype[7] == $past(port_reg[0].otype[7]) &&
                      port_reg[0].pu[7] == $past(port_reg[0].pu[7]))
      else $error("locked setting changed");
   a_reset_latch: assert property (@(posedge i_mclk)
      i_sys_rst |=> port_reg[0].data == 8'hFF && port_reg[2].data == 8'hFF)
      else $error("latch not FFh after reset");
   a_inactive_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !act12 [*2] |-> o_gpio_oe[15:0] == 16'h0000 && o_pullup_en[15:0] == 16'h0000)
      else $error("inactive port drives pins");
   a_push_pull: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (act12 && port_reg[0].dir[0] && port_reg[0].otype[0]) |=>
      o_gpio_oe[0] && o_gpio_out[0] == $past(port_reg[0].data[0]))
      else $error("push-pull bit not driven");
   a_open_drain: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (act12 && port_reg[0].dir[0] && !port_reg[0].otype[0] &&
       port_reg[0].data[0]) |=> !o_gpio_oe[0])
      else $error("open-drain high bit driven");
   a_route_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (act12 && route_on && port_reg[0].dir[1] && !g10_act) |=>
      o_gpio_oe[1] && !o_gpio_out[1])
      else $error("routed pin not driven low");
   a_read_latch: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (pready_next && !i_pwrite && port_hit && !bank && off == 3'h0 &&
       act12 && port_reg[0].dir == 8'hFF) |=>
      o_prdata[7:0] == $past(port_reg[0].data))
      else $error("output read not from latch");
endmodule : tpg_top
`default_nettype wire

// >>> bench/tpg_board.sv
// Board-side pin model for the three-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module tpg_board
   import tpg_pkg::*;
(
   // Clock
   input  wire logic                i_mclk,
   // Block side
   input  wire logic [TPG_NPIN-1:0] i_out,
   input  wire logic [TPG_NPIN-1:0] i_oe,
   input  wire logic [TPG_NPIN-1:0] i_pu,
   // Board drive
   input  wire logic [TPG_NPIN-1:0] i_ext_val,
   input  wire logic [TPG_NPIN-1:0] i_ext_en,
   // Resolved levels
   output logic      [TPG_NPIN-1:0] o_level
);
   // ==========================================================
   // Pin resolution; an undriven pin without pull-up wanders
   logic [TPG_NPIN-1:0] float_reg = '0;
   always @(posedge i_mclk) float_reg <= ~float_reg;
   always_comb begin
      for (int k = 0; k < TPG_NPIN; k++) begin
         if (i_oe[k]) o_level[k] = i_out[k];
         else if (i_ext_en[k]) o_level[k] = i_ext_val[k];
         else if (i_pu[k]) o_level[k] = 1'b1;
         else o_level[k] = float_reg[k];
      end
   end
endmodule : tpg_board
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the three-port GPIO block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
   fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb;
   import tpg_pkg::*;
   localparam logic [25:0] SEL_M = 26'h3FF3060;
   logic                i_mclk, i_sys_rst, psel, penable, pwrite;
   logic                pready, pslverr, power_on_control_out, rerr;
   logic [31:0]         paddr, pwdata, prdata, rv;
   logic [31:0]         seed = 32'hA951708E;
   logic [7:0]          rdat;
   logic [2:0]          wake;
   logic [TPG_NPIN-1:0] pin, gout, goe, gpu, gsel, ext_val, ext_en;
   int                  fails, cmp_count, mreg [0:15];
   bit                  act, fe2;
   // ==========================================================
   // Design and board
   tpg_top DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_gpio_in(pin), .o_gpio_out(gout),
      .o_gpio_oe(goe), .o_pullup_en(gpu), .o_gpio_sel(gsel),
      .o_wake_src(wake), .o_power_on_control_out_src(power_on_control_out));
   tpg_board BOARD (.i_mclk(i_mclk), .i_out(gout), .i_oe(goe), .i_pu(gpu),
      .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pin));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // ==========================================================
   // Helpers and reference model
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic bit mact(int b, int o);
      return (b == 1 && o > 3) ? act : act && fe2;
   endfunction : mact
   function automatic int mrd(int b, int o);
      int v;
      int d;
      v = mreg[b * 8 + o];
      d = mreg[b * 8 + o + 1];
      if (o % 4 == 0 && !(b == 1 && o == 0))
         v = (v & d) | (int'(ext_val[(b + o / 4) * 8 +: 8]) & ~d);
      if (!mact(b, o)) v = 0;
      return v & 8'hFF;
   endfunction : mrd
   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   task automatic apb(input bit wr, input logic [31:0] a, input int d);
      int n;
      @(posedge i_mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= 32'(d & 8'hFF);
      @(posedge i_mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         conclude();
      end
      rdat = prdata[7:0];
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cfg(input logic [7:0] idx, input int v);
      apb(1, 32'h0010_0000 + {22'h0, idx, 2'h0}, v);
      if (idx == TPG_IDX_ACTIVATE) act = v[0];
      if (idx == TPG_IDX_FUNC_EN2) fe2 = v[7];
   endtask : cfg
   task automatic preg(input int b, input int o, input int v);
      int m;
      cfg(TPG_IDX_CHIP_CFG2, b << 7);
      apb(1, 32'h20 + 4 * o, v);
      m = 0;
      if (!mact(b, o) || (b == 1 && o == 3)) return;
      if (b == 0 && o < 4) m = mreg[8] & ((o == 0) ? mreg[1] : 8'hFF);
      if (b == 1 && o == 0) v = mreg[8] | (v & 8'hF0);
      if (b == 1 && (o == 1 || o == 2)) v = v & 1;
      mreg[b * 8 + o] = (mreg[b * 8 + o] & m) | (v & ~m & 8'hFF);
   endtask : preg
   task automatic pchk(input int b, input int o);
      cfg(TPG_IDX_CHIP_CFG2, b << 7);
      apb(0, 32'h20 + 4 * o, 0);
      `CHK("pslverr", (b == 1 && o == 3), rerr)
      if (!(b == 1 && o == 3)) `CHK("port reg", mrd(b, o), rdat)
   endtask : pchk
   task automatic setpins(input logic [23:0] v);
      @(posedge i_mclk);
      ext_val <= {v[13], v[12], v};
      repeat (8) @(posedge i_mclk);
   endtask : setpins
   // ==========================================================
   // Main sequence
   initial begin
      i_sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      ext_val = '0;
      ext_en = '1;
      mreg = '{8'hFF, 0, 0, 8'hFF, 8'hFF, 0, 0, 8'hFF,
               0, 0, 0, 0, 8'hFF, 0, 0, 8'hFF};
      repeat (20) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      cfg(TPG_IDX_BASE_LO, 8'h08);
      pchk(0, 3);
      cfg(TPG_IDX_ACTIVATE, 1);
      pchk(1, 7);
      pchk(0, 3);
      cfg(TPG_IDX_FUNC_EN2, 8'h80);
      for (int k = 0; k < 16; k++) pchk(k / 8, k % 8);
      $display("Test 1 done");
      setpins(24'h00003C);
      pchk(0, 0);
      preg(0, 1, 8'hFF);
      pchk(0, 0);
      preg(0, 1, 0);
      preg(0, 0, 8'h5A);
      `CHK("oe", 8'h00, goe[7:0])
      preg(0, 2, 8'hFF);
      preg(0, 1, 8'hFF);
      repeat (2) @(posedge i_mclk);
      `CHK("out", 8'h5A, gout[7:0])
      pchk(0, 0);
      preg(0, 2, 0);
      repeat (2) @(posedge i_mclk);
      `CHK("od oe", 8'h85, goe[7:0])
      $display("Test 2 done");
      preg(0, 1, 8'h02);
      preg(0, 2, 8'h02);
      preg(0, 0, 8'hFD);
      preg(1, 2, 1);
      for (int p = 0; p < 2; p++) begin
         preg(1, 1, p);
         for (int l = 0; l < 2; l++) begin
            rv = xs();
            rv[0] = l[0];
            setpins(rv[23:0]);
            `CHK("route", (l == p), gout[1])
            `CHK("route oe", 1'b1, goe[1])
            `CHK("wake", {rv[3], rv[2], rv[0]}, wake)
            `CHK("power_on_control_out", rv[0], power_on_control_out)
         end
      end
      preg(1, 2, 0);
      $display("Test 3 done");
      preg(1, 0, 8'hF0);
      preg(1, 0, 0);
      pchk(1, 0);
      preg(0, 2, 8'hFF);
      preg(0, 3, 0);
      preg(0, 1, 8'hFF);
      for (int k = 1; k < 4; k++) pchk(0, k);
      $display("Test 4 done");
      for (int k = 0; k < 24; k++) begin
         rv = xs();
         if (rv[3] && rv[2:0] < 4) rv[2:0] = 3'h0;
         preg(rv[3], rv[2:0], rv[15:8]);
         pchk(rv[3], rv[2:0]);
      end
      $display("Test 5 done");
      for (int s = 0; s < 2; s++) begin
         cfg(TPG_IDX_PWR_CTL3, s ? 8'h1B : 0);
         cfg(TPG_IDX_PWR_CTL5, s ? 8'h40 : 0);
         cfg(TPG_IDX_CHIP_CFG1, s ? 8'h18 : 0);
         cfg(TPG_IDX_CHIP_CFG3, s);
         repeat (2) @(posedge i_mclk);
         `CHK("select", s ? SEL_M : 26'h0, gsel & SEL_M)
      end
      $display("Test 6 done");
      `CHK("pullup", mreg[3], gpu[7:0])
      cfg(TPG_IDX_FUNC_EN2, 0);
      pchk(0, 1);
      preg(0, 1, 8'hFF);
      pchk(1, 5);
      `CHK("off oe", 16'h0, goe[15:0])
      `CHK("off pu", 16'h0, gpu[15:0])
      cfg(TPG_IDX_FUNC_EN2, 8'h80);
      pchk(0, 1);
      $display("Test 7 done");
      conclude();
   end
endmodule : tb
`default_nettype wire
